// ===== rtl/genset_customer_io_supervisor.sv
// Customer discrete I/O supervisor of a generator-set controller
`timescale 1ns/100ps
module genset_customer_io_supervisor #(
  parameter int TICK_CYC  = genset_io_pkg::TICK_CYCLES,
  parameter int DUMP_TICK = genset_io_pkg::LOAD_DUMP_TICKS,
  parameter int DEB_CYC   = genset_io_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [8:0]             custPinN,
  input  wire genset_io_pkg::mode_e   modeSel,
  input  wire logic [3:0]             faultIsShutdown,
  input  wire logic                   asleep,
  input  wire logic                   panelReset,
  input  wire logic                   overload,
  input  wire logic                   underFreq,
  input  wire logic [15:0]            voltNow,
  input  wire logic [15:0]            voltNominal,
  input  wire logic [15:0]            freqNow,
  input  wire logic [15:0]            freqNominal,
  input  wire logic                   runPilot,
  input  wire logic                   atOperSpeed,
  input  wire logic [2:0]             runRelayFitted,
  input  wire logic [71:0]            rtdTemps,
  input  wire logic                   trimUp,
  input  wire logic                   trimDown,
  input  wire logic                   trimSave,
  input  wire logic                   engineStart,
  input  wire logic                   msgWrEn,
  input  wire logic [1:0]             msgWrSel,
  input  wire logic [3:0]             msgWrIdx,
  input  wire logic [7:0]             msgWrChar,
  input  wire logic [3:0]             dispIdx,
  output genset_io_pkg::relays_s      relays,
  output logic                        startReq,
  output logic                        wakeReq,
  output logic                        lowFuelWarn,
  output logic [3:0]                  custWarn,
  output logic [3:0]                  custShut,
  output logic                        estopLatched,
  output logic                        idleActive,
  output logic                        voltInhibit,
  output logic [11:0]                 govSpeedRpm,
  output logic [7:0]                  oilWarnPoint,
  output logic [7:0]                  oilShutPoint,
  output logic [5:0]                  rtdOver,
  output logic                        rtdTrip,
  output logic [6:0]                  torqueTrim,
  output logic [7:0]                  dispChar,
  output logic [9:0]                  dispCode,
  output logic                        dispValid
);
  import genset_io_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Input conditioning
  logic [8:0] inAct;
  custIn_s    cin;

  for (genvar g = 0; g < NUM_INPUTS; g++) begin : gDeb
    input_debounce #(.DEB_CYCLES(DEB_CYC)) uDeb (
      .clk    (clk),
      .nrst   (nrst),
      .pinN   (custPinN[g]),
      .active (inAct[g])
    );
  end
  assign cin = custIn_s'(inAct);

  // ==========================================================
  // Decode
  wire modeAuto   = modeSel == MODE_AUTO;
  wire modeRun    = modeSel == MODE_RUN;
  wire awake      = !asleep;
  wire [3:0] needWake = 4'b0110;
  wire wakeSrc    = cin.lowFuel | (|(cin.custFault & needWake));
  wire remReset   = modeAuto & !cin.remoteStart & cin.faultReset;
  wire clrLatched = remReset | panelReset;
  wire lowFuelSet = cin.lowFuel & awake;
  wire [3:0] faultOk = cin.custFault & (~needWake | {4{awake}});
  wire [3:0] warnSet = faultOk & ~faultIsShutdown;
  wire [3:0] shutSet = faultOk & faultIsShutdown;
  wire anyWarnNxt = lowFuelSet | (|warnSet) |
                    ((lowFuelWarn | (|custWarn)) & !clrLatched);
  wire anyShutNxt = (|shutSet) | cin.remoteEstop |
                    ((|custShut) & !clrLatched) |
                    (estopLatched & !panelReset);
  wire idleNxt    = modeRun & cin.engineIdle;
  wire [19:0] vScaled = voltNow * READY_DEN;
  wire [19:0] vLimit  = voltNominal * READY_NUM;
  wire [19:0] fScaled = freqNow * READY_DEN;
  wire [19:0] fLimit  = freqNominal * READY_NUM;
  wire readyNxt   = (vScaled > vLimit) & (fScaled > fLimit);

  // ==========================================================
  // Latched faults and registered wake request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowFuelWarn  <= 1'b0;
      custWarn     <= '0;
      custShut     <= '0;
      estopLatched <= 1'b0;
      wakeReq      <= 1'b0;
    end else begin
      lowFuelWarn  <= lowFuelSet | (lowFuelWarn & !clrLatched);
      custWarn     <= warnSet | (custWarn & ~{4{clrLatched}});
      custShut     <= shutSet | (custShut & ~{4{clrLatched}});
      estopLatched <= cin.remoteEstop | (estopLatched & !panelReset);
      wakeReq      <= asleep & wakeSrc;
    end
  end

  // ==========================================================
  // Load dump persistence timer
  localparam int PW = $clog2(TICK_CYC + 1);
  localparam int DW = $clog2(DUMP_TICK + 1);
  logic [PW-1:0] preCnt_r;
  logic [DW-1:0] dumpCnt_r;
  wire           dumpCond = overload | underFreq;
  wire           tick     = preCnt_r == PW'(TICK_CYC - 1);
  wire           dumpDone = dumpCnt_r == DW'(DUMP_TICK);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_r  <= '0;
      dumpCnt_r <= '0;
    end else if (!dumpCond) begin
      preCnt_r  <= '0;
      dumpCnt_r <= '0;
    end else begin
      preCnt_r  <= tick ? '0 : preCnt_r + 1'b1;
      if (tick && !dumpDone) begin
        dumpCnt_r <= dumpCnt_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Relays and engine commands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      relays      <= '0;
      startReq    <= 1'b0;
      idleActive  <= 1'b0;
      voltInhibit <= 1'b0;
      govSpeedRpm <= RATED_RPM;
      oilWarnPoint <= OILP_WARN_NORM;
      oilShutPoint <= OILP_SHUT_NORM;
    end else begin
      relays.breakerTrip    <= anyShutNxt;
      relays.commonAlarm    <= anyWarnNxt | anyShutNxt;
      relays.loadDump       <= dumpCond & dumpDone;
      relays.readyToLoad    <= readyNxt;
      relays.switchedSupply <= runPilot;
      relays.runRelay       <= runRelayFitted & {3{atOperSpeed}};
      relays.alarmRelay     <= anyWarnNxt | anyShutNxt;
      startReq    <= modeAuto & cin.remoteStart & !anyShutNxt;
      idleActive  <= idleNxt;
      voltInhibit <= idleNxt;
      govSpeedRpm <= idleNxt ? IDLE_RPM : RATED_RPM;
      oilWarnPoint <= idleNxt ? OILP_WARN_IDLE : OILP_WARN_NORM;
      oilShutPoint <= idleNxt ? OILP_SHUT_IDLE : OILP_SHUT_NORM;
    end
  end

  // ==========================================================
  // Temperature relay
  rtd_compare #(.ZONES(NUM_RTD), .SETPOINT(RTD_SETPOINT)) uRtd (
    .clk     (clk),
    .nrst    (nrst),
    .temps   (rtdTemps),
    .overSet (rtdOver),
    .tripped (rtdTrip)
  );

  // ==========================================================
  // Torque trim
  logic [6:0] trimSaved_r;
  wire        trimInc = trimUp & !trimDown & (torqueTrim < TRIM_MAX);
  wire        trimDec = trimDown & !trimUp & (torqueTrim != 7'd0);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      torqueTrim  <= TRIM_RST;
      trimSaved_r <= TRIM_RST;
    end else begin
      if (engineStart) begin
        torqueTrim <= trimSaved_r;
      end else if (trimInc) begin
        torqueTrim <= torqueTrim + 7'd1;
      end else if (trimDec) begin
        torqueTrim <= torqueTrim - 7'd1;
      end
      if (trimSave) begin
        trimSaved_r <= torqueTrim;
      end
    end
  end

  // ==========================================================
  // Fault messages
  logic [7:0] msgMem [NUM_CUST][MSG_CHARS];
  logic [1:0] showSel;
  wire  [3:0] shown = cin.custFault;
  assign showSel = shown[0] ? 2'd0 : shown[1] ? 2'd1 :
                   shown[2] ? 2'd2 : 2'd3;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < MSG_CHARS; c++) begin
        msgMem[0][c] <= MSG_DEF0[8*(MSG_CHARS-1-c) +: 8];
        msgMem[1][c] <= MSG_DEF1[8*(MSG_CHARS-1-c) +: 8];
        msgMem[2][c] <= MSG_DEF2[8*(MSG_CHARS-1-c) +: 8];
        msgMem[3][c] <= MSG_DEF3[8*(MSG_CHARS-1-c) +: 8];
      end
    end else if (msgWrEn) begin
      msgMem[msgWrSel][msgWrIdx] <= msgWrChar;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dispChar  <= 8'h00;
      dispCode  <= 10'h000;
      dispValid <= 1'b0;
    end else begin
      dispChar  <= msgMem[showSel][dispIdx];
      dispCode  <= CUST_CODE_BASE + 10'(showSel);
      dispValid <= |shown;
    end
  end

  // ==========================================================
  // Checks
  sequence resetReq;
    modeAuto && !cin.remoteStart && cin.faultReset && !panelReset;
  endsequence
  sequence noNewFault;
    !(|cin.custFault) && !cin.lowFuel && !cin.remoteEstop;
  endsequence

  chk_reset_keeps_estop: assert property (
    (estopLatched and resetReq) |=> estopLatched)
    else $error("remote reset cleared emergency stop");
  chk_reset_clears_warn: assert property (
    (resetReq and noNewFault) |=> !lowFuelWarn && custWarn == 4'h0)
    else $error("fault reset did not clear warnings");
  chk_reset_blocked: assert property (
    (lowFuelWarn && cin.remoteStart && !panelReset) |=> lowFuelWarn)
    else $error("reset acted while remote start grounded");
  chk_breaker_trip: assert property (
    ((|custShut && !clrLatched) || (estopLatched && !panelReset)) |=>
    relays.breakerTrip)
    else $error("shutdown without breaker trip");
  chk_common_alarm: assert property (
    ##1 relays.commonAlarm == relays.alarmRelay)
    else $error("common and alarm relays disagree");
  chk_idle_in_auto: assert property (
    modeAuto |=> !idleActive && govSpeedRpm == 12'd1800)
    else $error("idle engaged in auto");
  chk_idle_speed: assert property (
    (modeRun && cin.engineIdle) |=> govSpeedRpm == 12'd800 &&
    voltInhibit && oilShutPoint == OILP_SHUT_IDLE)
    else $error("idle speed or thresholds wrong");
  chk_dump_timing: assert property (
    $rose(relays.loadDump) |-> $past(dumpCnt_r) == DW'(DUMP_TICK))
    else $error("load dump closed early");
  chk_dump_restart: assert property (
    !dumpCond |=> (dumpCnt_r == '0) and (!relays.loadDump [*2]))
    else $error("dump timer not restarted");
  chk_trim_range: assert property (
    torqueTrim <= 7'd100)
    else $error("torque trim out of range");
  chk_trim_restart: assert property (
    engineStart |=> torqueTrim == $past(trimSaved_r))
    else $error("restart did not load saved trim");
  chk_wake_first: assert property (
    (asleep && cin.custFault[1]) |=> wakeReq && !$rose(custWarn[1]))
    else $error("fault raised before wake");
  chk_start_auto: assert property (
    startReq |-> $past(modeAuto) && $past(cin.remoteStart))
    else $error("start without auto remote start");
  chk_supply: assert property (
    runPilot ##1 runPilot |-> relays.switchedSupply)
    else $error("switched supply not following pilot");

endmodule : genset_customer_io_supervisor

// ===== rtl/genset_io_pkg.sv
// Shared constants, types and carriers of the customer I/O supervisor
package genset_io_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ            = 20_000_000;
  localparam int TICK_US           = 1000;
  localparam int TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int LOAD_DUMP_MS      = 5000;
  localparam int LOAD_DUMP_TICKS   = LOAD_DUMP_MS * 1000 / TICK_US;
  localparam int DEBOUNCE_US       = 10000;
  localparam int DEBOUNCE_CYCLES   = CLK_HZ / 1_000_000 * DEBOUNCE_US;

  // ==========================================================
  // Speeds, thresholds, trim
  localparam logic [11:0] IDLE_RPM        = 12'd800;
  localparam logic [11:0] RATED_RPM       = 12'd1800;
  localparam logic [7:0]  OILP_WARN_NORM  = 8'd30;
  localparam logic [7:0]  OILP_SHUT_NORM  = 8'd20;
  localparam logic [7:0]  OILP_WARN_IDLE  = 8'd15;
  localparam logic [7:0]  OILP_SHUT_IDLE  = 8'd10;
  localparam logic [3:0]  READY_NUM       = 4'd9;
  localparam logic [3:0]  READY_DEN       = 4'd10;
  // Trim in 0.01 % duty steps, 0 to +1 %
  localparam logic [6:0]  TRIM_MAX        = 7'd100;
  localparam logic [6:0]  TRIM_RST        = 7'd0;
  localparam logic [11:0] RTD_SETPOINT    = 12'd1550;

  // ==========================================================
  // Counts and messages
  localparam int NUM_CUST    = 4;
  localparam int NUM_RUNREL  = 3;
  localparam int NUM_RTD     = 6;
  localparam int MSG_CHARS   = 16;
  localparam int NUM_INPUTS  = 9;
  // Fault code base is arbitrary
  localparam logic [9:0] CUST_CODE_BASE = 10'd100;
  localparam logic [127:0] MSG_DEF0 = "RACK POSITION   ";
  localparam logic [127:0] MSG_DEF1 = "GRND FAULT      ";
  localparam logic [127:0] MSG_DEF2 = "DAY TANK        ";
  localparam logic [127:0] MSG_DEF3 = "HIGH GEN TEMP   ";

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_OFF  = 2'b00,
    MODE_RUN  = 2'b01,
    MODE_AUTO = 2'b11
  } mode_e;

  // Debounced ground-active inputs, 1 = grounded
  typedef struct packed {
    logic       remoteStart;
    logic       lowFuel;
    logic [3:0] custFault;
    logic       faultReset;
    logic       engineIdle;
    logic       remoteEstop;
  } custIn_s;

  typedef struct packed {
    logic       breakerTrip;
    logic       commonAlarm;
    logic       loadDump;
    logic       readyToLoad;
    logic       switchedSupply;
    logic [2:0] runRelay;
    logic       alarmRelay;
  } relays_s;

endpackage : genset_io_pkg

// ===== rtl/input_debounce.sv
// Two-stage synchroniser and debouncer for one ground-active input
`timescale 1ns/100ps
module input_debounce #(
  parameter int DEB_CYCLES = 200000
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic pinN,
  output logic      active
);
  import genset_io_pkg::*;

  localparam int CW = $clog2(DEB_CYCLES + 1);

  logic          meta_r;
  logic          sync_r;
  logic [CW-1:0] cnt_r;
  wire           differs = sync_r != active;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= ~pinN;
      sync_r <= meta_r;
    end
  end

  // Accept a new level only after it stands DEB_CYCLES
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= '0;
      active <= 1'b0;
    end else if (!differs) begin
      cnt_r  <= '0;
    end else if (cnt_r == CW'(DEB_CYCLES - 1)) begin
      cnt_r  <= '0;
      active <= sync_r;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end

  chk_deb_stable: assert property (@(posedge clk) disable iff (!nrst)
    $changed(active) |-> $past(sync_r) == active)
    else $error("debounced level changed without stable input");

endmodule : input_debounce

// ===== rtl/rtd_compare.sv
// Six-zone temperature compare against one fixed setpoint
`timescale 1ns/100ps
module rtd_compare #(
  parameter int          ZONES    = 6,
  parameter logic [11:0] SETPOINT = 12'd1550
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ZONES*12-1:0] temps,
  output logic [ZONES-1:0]       overSet,
  output logic                   tripped
);
  import genset_io_pkg::*;

  logic [ZONES-1:0] overNxt;

  always_comb begin
    for (int i = 0; i < ZONES; i++) begin
      overNxt[i] = temps[i*12 +: 12] > SETPOINT;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overSet <= '0;
      tripped <= 1'b0;
    end else begin
      overSet <= overNxt;
      tripped <= |overNxt;
    end
  end

  chk_rtd_trip: assert property (@(posedge clk) disable iff (!nrst)
    ##1 tripped == (|overSet))
    else $error("rtd trip disagrees with zone flags");

endmodule : rtd_compare

// ===== sim/field_switches.sv
// Field contacts wired to the customer terminals
`timescale 1ns/100ps
module field_switches (
  input  wire logic [8:0] closeCmd,
  input  wire logic [8:0] chatter,
  output logic      [8:0] custPinN
);
  // ground-active contacts
  // Closed contact grounds pin, open pin rests at pull-up, chatter flips it
  assign custPinN = ~closeCmd ^ chatter;
endmodule : field_switches

// ===== sim/tb_top.sv
// Self-checking bench of the customer I/O supervisor
`timescale 1ns/100ps
module tb_top;
  import genset_io_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [8:0]  closeCmd = '0;
  logic [8:0]  chatter = '0;
  wire  [8:0]  custPinN;
  mode_e       modeSel = MODE_AUTO;
  logic [3:0]  faultIsShutdown = '0;
  logic        asleep = 0, panelReset = 0, overload = 0, underFreq = 0;
  logic [15:0] voltNow = 0, voltNominal = 0, freqNow = 0, freqNominal = 0;
  logic        runPilot = 0, atOperSpeed = 0;
  logic [2:0]  runRelayFitted = 0;
  logic [71:0] rtdTemps = 0;
  logic        trimUp = 0, trimDown = 0, trimSave = 0, engineStart = 0;
  logic        msgWrEn = 0;
  logic [1:0]  msgWrSel = 0;
  logic [3:0]  msgWrIdx = 0, dispIdx = 0;
  logic [7:0]  msgWrChar = 0;
  relays_s     relays;
  logic        startReq, wakeReq, lowFuelWarn, estopLatched, idleActive;
  logic        voltInhibit, rtdTrip, dispValid;
  logic [3:0]  custWarn, custShut;
  logic [11:0] govSpeedRpm;
  logic [7:0]  oilWarnPoint, oilShutPoint, dispChar;
  logic [5:0]  rtdOver;
  logic [6:0]  torqueTrim;
  logic [9:0]  dispCode;
  logic [31:0] seed = 32'hC725;
  logic [31:0] r;
  int          miscompares = 0, cmpCount = 0, cyc = 0;

  always #25 clk = ~clk;

  field_switches sw_u (.closeCmd, .chatter, .custPinN);

  genset_customer_io_supervisor #(.TICK_CYC(4), .DUMP_TICK(5), .DEB_CYC(3))
  dut_u (.clk, .nrst, .custPinN, .modeSel, .faultIsShutdown, .asleep,
    .panelReset, .overload, .underFreq, .voltNow, .voltNominal, .freqNow,
    .freqNominal, .runPilot, .atOperSpeed, .runRelayFitted, .rtdTemps,
    .trimUp, .trimDown, .trimSave, .engineStart, .msgWrEn, .msgWrSel,
    .msgWrIdx, .msgWrChar, .dispIdx, .relays, .startReq, .wakeReq,
    .lowFuelWarn, .custWarn, .custShut, .estopLatched, .idleActive,
    .voltInhibit, .govSpeedRpm, .oilWarnPoint, .oilShutPoint, .rtdOver,
    .rtdTrip, .torqueTrim, .dispChar, .dispCode, .dispValid);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [6:0] rtdExp(input logic [71:0] t);
    logic [5:0] o;
    for (int z = 0; z < 6; z++) o[z] = t[12*z +: 12] > RTD_SETPOINT;
    return {|o, o};
  endfunction : rtdExp

  function automatic logic [7:0] defChar(input int i);
    case (i)
      0: return MSG_DEF0[127:120];
      1: return MSG_DEF1[127:120];
      2: return MSG_DEF2[127:120];
      default: return MSG_DEF3[127:120];
    endcase
  endfunction : defChar

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  task automatic pulse(ref logic s);
    s = 1'b1;
    wt(1);
    s = 1'b0;
    wt(1);
  endtask : pulse

  task automatic clearFaults();
    closeCmd[2] = 1'b1;
    wt(10);
    closeCmd[2] = 1'b0;
    wt(10);
  endtask : clearFaults

  task stop_test();
    $display("Compares %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    wt(5);
    nrst = 1'b1;
    wt(1);
    chk({govSpeedRpm, oilWarnPoint}, {RATED_RPM, OILP_WARN_NORM});
    chk({torqueTrim, relays}, {TRIM_RST, 9'h000});
    chatter[7] = 1'b1;
    wt(1);
    chatter[7] = 1'b0;
    wt(10);
    chk(lowFuelWarn, 0);
    closeCmd[8] = 1'b1;
    wt(10);
    chk(startReq, 1);
    closeCmd[8] = 1'b0;
    asleep = 1'b1;
    closeCmd[7] = 1'b1;
    wt(10);
    chk({wakeReq, lowFuelWarn}, 2'b10);
    asleep = 1'b0;
    wt(3);
    chk(lowFuelWarn, 1);
    chk({relays.commonAlarm, relays.alarmRelay}, 2'b11);
    closeCmd[7] = 1'b0;
    clearFaults();
    chk(lowFuelWarn, 0);
    for (int i = 0; i < 4; i++) begin
      faultIsShutdown = 4'(rnd());
      asleep = (i == 1) || (i == 2);
      closeCmd[3+i] = 1'b1;
      wt(10);
      if (asleep) begin
        chk({wakeReq, custWarn | custShut}, 5'h10);
        asleep = 1'b0;
        wt(3);
      end
      chk(custShut, 32'(faultIsShutdown[i]) << i);
      chk(custWarn, 32'(!faultIsShutdown[i]) << i);
      chk(relays.breakerTrip, faultIsShutdown[i]);
      chk(relays.commonAlarm, 1);
      chk({dispValid, dispCode}, 11'h400 | (CUST_CODE_BASE + i));
      chk(dispChar, defChar(i));
      closeCmd[3+i] = 1'b0;
      closeCmd[8] = 1'b1;
      closeCmd[2] = 1'b1;
      wt(10);
      chk(custWarn | custShut, 1 << i);
      closeCmd[8] = 1'b0;
      wt(10);
      chk({relays.breakerTrip, custWarn | custShut}, 0);
      closeCmd[2] = 1'b0;
    end
    // fault 3 text rewritten at index 5
    msgWrSel = 2'h3;
    msgWrIdx = 4'h5;
    msgWrChar = 8'(rnd());
    pulse(msgWrEn);
    dispIdx = 4'h5;
    closeCmd[6] = 1'b1;
    wt(10);
    chk(dispChar, msgWrChar);
    dispIdx = 4'h0;
    wt(2);
    chk(dispChar, defChar(3));
    closeCmd[6] = 1'b0;
    clearFaults();
    closeCmd[0] = 1'b1;
    wt(10);
    chk({estopLatched, relays.breakerTrip}, 2'b11);
    closeCmd[0] = 1'b0;
    clearFaults();
    chk(estopLatched, 1);
    pulse(panelReset);
    wt(1);
    chk({estopLatched, relays.breakerTrip}, 0);
    modeSel = MODE_RUN;
    closeCmd[1] = 1'b1;
    wt(10);
    chk({idleActive, voltInhibit, govSpeedRpm}, {2'b11, IDLE_RPM});
    chk({oilWarnPoint, oilShutPoint}, {OILP_WARN_IDLE, OILP_SHUT_IDLE});
    modeSel = MODE_AUTO;
    wt(3);
    chk({idleActive, voltInhibit, govSpeedRpm}, {2'b00, RATED_RPM});
    chk({oilWarnPoint, oilShutPoint}, {OILP_WARN_NORM, OILP_SHUT_NORM});
    modeSel = MODE_OFF;
    closeCmd[8] = 1'b1;
    wt(10);
    chk({startReq, idleActive}, 2'b00);
    closeCmd[8] = 1'b0;
    modeSel = MODE_AUTO;
    closeCmd[1] = 1'b0;
    for (int k = 0; k < 2; k++) begin
      {overload, underFreq} = k ? 2'b01 : 2'b10;
      wt(14);
      chk(relays.loadDump, 0);
      if (k == 0) begin
        overload = 1'b0;
        wt(1);
        overload = 1'b1;
        wt(14);
        chk(relays.loadDump, 0);
      end
      wt(11);
      chk(relays.loadDump, 1);
      {overload, underFreq} = 2'b00;
      wt(3);
      chk(relays.loadDump, 0);
    end
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      voltNominal = 16'(rnd());
      freqNominal = 16'(rnd());
      voltNow = 16'(voltNominal * (32'd85 + rnd() % 20) / 100);
      freqNow = 16'(freqNominal * (32'd85 + rnd() % 20) / 100);
      if (n == 0) begin
        {voltNominal, voltNow, freqNominal} = {16'd1000, 16'd900, 16'd600};
      end
      {runPilot, atOperSpeed, runRelayFitted} = r[4:0];
      for (int z = 0; z < 6; z++)
        rtdTemps[12*z +: 12] = RTD_SETPOINT - 12'd8 + 12'(r[4*z+5 +: 4]);
      wt(3);
      chk(relays.readyToLoad, 32'(voltNow) * 10 > 32'(voltNominal) * 9
        && 32'(freqNow) * 10 > 32'(freqNominal) * 9);
      chk(relays.switchedSupply, runPilot);
      chk(relays.runRelay, runRelayFitted & {3{atOperSpeed}});
      chk({rtdTrip, rtdOver}, rtdExp(rtdTemps));
    end
    trimUp = 1'b1;
    wt(105);
    trimUp = 1'b0;
    wt(1);
    chk(torqueTrim, TRIM_MAX);
    pulse(trimSave);
    trimDown = 1'b1;
    wt(30);
    trimDown = 1'b0;
    wt(1);
    chk(torqueTrim, TRIM_MAX - 30);
    pulse(engineStart);
    chk(torqueTrim, TRIM_MAX);
    trimDown = 1'b1;
    wt(120);
    trimDown = 1'b0;
    wt(1);
    chk(torqueTrim, 0);
    stop_test();
  end
endmodule : tb_top
